// ===== hw/sasi_integrity.sv
// Purpose: sample crc, setup crc, third-input select and setup write lock
// Assumes: converter results and the output-cycle strobe are synchronous to clk
// Notes: register accesses arrive already decoded from the serial port
`timescale 1ns/1ps
`default_nettype none

module sasi_integrity #(
	parameter int unsigned TEMP_SETTLE_CYCLES = sasi_pkg::TEMP_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cycle_strobe,
	input wire logic [23:0] current_result,
	input wire logic [23:0] first_voltage_result,
	input wire logic [23:0] third_conv_result,
	input wire logic two_channel_variant,
	input wire logic [7:0] thermal_offset_fuse,
	input wire logic [7:0] flag_word_one,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic burst_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [23:0] reg_rdata,
	output logic reg_rvalid,
	output logic [1:0] output_rate_field,
	output logic narrow_band_bit,
	output logic third_input_temp,
	output logic [7:0] interference_control,
	output logic write_protect,
	output logic temp_settled
);
	import sasi_pkg::*;

	// all state of the block in one register
	typedef struct packed {
		logic [7:0] setup;
		logic [7:0] ifc;
		logic locked;
		logic [7:0] trim;
		logic variant;
		logic [23:0] cur;
		logic [23:0] v1;
		logic [23:0] v2;
		logic [15:0] smp_crc;
		logic [15:0] pend_crc;
		logic [15:0] set_crc;
		logic crc_chg;
		logic prot;
		logic smp_go;
		logic set_go;
		logic boot;
		logic [23:0] rdata;
		logic rvalid;
		sasi_burst_e burst;
		logic [SETTLE_W-1:0] settle;
		logic settled;
		logic sel_temp;
	} sasi_state_s;

	// settling load; twenty bits are enough for 5 ms at 200 MHz
	localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(TEMP_SETTLE_CYCLES);

	// current and next state
	sasi_state_s st_q;
	sasi_state_s st_d;

	// one handshake bundle per crc engine
	sasi_crc_if smp_if ();
	sasi_crc_if set_if ();

	// sample crc engine, 72 bits
	sasi_crc_engine #(
		.LEN(SAMPLE_CRC_BITS)
	) u_sample_crc (
		.clk(clk),
		.rst(rst),
		.bus(smp_if.eng)
	);

	// setup crc engine, 64 bits
	sasi_crc_engine #(
		.LEN(SETUP_CRC_BITS)
	) u_setup_crc (
		.clk(clk),
		.rst(rst),
		.bus(set_if.eng)
	);

	// flag word zero as software sees it
	// bit 0 and the other status bits are not modelled here and read as zero
	function automatic logic [7:0] flag_zero(input logic prot, input logic chg);
		logic [7:0] w;
		w = 8'h00;
		w[FLAG0_PROT_BIT] = prot;
		w[FLAG0_CRC_CHG_BIT] = chg;
		return w;
	endfunction : flag_zero

	// read mux; unmapped and write-only indices read as zero
	// reads are never blocked, whatever the lock state
	function automatic logic [23:0] read_word(input logic [3:0] a, input sasi_state_s s,
		input logic [7:0] f1);
		logic [23:0] w;
		w = 24'h00_0000;
		unique case (a)
			ADDR_CURRENT: w = s.cur;
			ADDR_FIRST_V: w = s.v1;
			ADDR_SECOND_V: w = s.v2;
			ADDR_SAMPLE_CRC: w = {8'h00, s.smp_crc};
			ADDR_SETUP: w = {16'h0000, s.setup};
			ADDR_FLAG_ZERO: w = {16'h0000, flag_zero(s.prot, s.crc_chg)};
			ADDR_SETUP_CRC: w = {8'h00, s.set_crc};
			ADDR_IFC: w = {16'h0000, s.ifc};
			ADDR_TRIM: w = {16'h0000, s.trim};
			ADDR_FLAG_ONE: w = {16'h0000, f1};
			default: w = 24'h00_0000;
		endcase
		return w;
	endfunction : read_word

	// the setup crc sees only the protection and array bits of the flag words
	logic [7:0] flag0_array;
	logic [7:0] flag1_array;
	always_comb begin
		flag0_array = 8'h00;
		flag0_array[FLAG0_PROT_BIT] = st_q.prot;
		flag1_array = 8'h00;
		flag1_array[FLAG1_ARRAY_BIT] = flag_word_one[FLAG1_ARRAY_BIT];
	end

	// engine starts are registered pulses from the strobe, the setup engine's also from the boot flag
	assign smp_if.start = st_q.smp_go;
	assign smp_if.data = {st_q.v2, st_q.v1, st_q.cur};
	assign set_if.start = st_q.set_go;
	// setup array: five bytes low first, top three bytes and engine slack are zero
	assign set_if.data = {32'h0000_0000, flag1_array, flag0_array, st_q.trim,
		st_q.ifc, st_q.setup};

	// next-state logic for the whole block
	always_comb begin
		logic flag_read;
		logic rate_full;
		flag_read = 1'b0;
		rate_full = (st_q.setup[CFG_RATE_HI:CFG_RATE_LO] == RATE_FULL);
		st_d = st_q;
		st_d.smp_go = 1'b0;
		st_d.set_go = 1'b0;
		st_d.boot = 1'b0;
		st_d.rvalid = 1'b0;
		st_d.trim = thermal_offset_fuse;
		st_d.variant = two_channel_variant;

		// first setup crc right after reset so the value reflects this part's trim
		if (st_q.boot) begin
			st_d.set_go = 1'b1;
		end

		// register writes; the lock register itself is never blocked
		// a blocked write is dropped with no sign to the host
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_LOCK: begin
					if (reg_wdata == LOCK_ENABLE) begin
						st_d.locked = 1'b1;
					end else if (reg_wdata == LOCK_DISABLE) begin
						st_d.locked = 1'b0;
					end
				end
				ADDR_SETUP: begin
					if (!st_q.locked) begin
						st_d.setup = reg_wdata;
					end
				end
				ADDR_IFC: begin
					if (!st_q.locked) begin
						st_d.ifc = reg_wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// burst read walks samples, sample crc, flag word zero
		unique case (st_q.burst)
			BURST_IDLE: begin
				if (burst_rd) begin
					st_d.burst = BURST_CUR;
				end else if (reg_rd) begin
					st_d.rdata = read_word(reg_addr, st_q, flag_word_one);
					st_d.rvalid = 1'b1;
					flag_read = (reg_addr == ADDR_FLAG_ZERO);
				end
			end
			BURST_CUR: begin
				st_d.rdata = st_q.cur;
				st_d.rvalid = 1'b1;
				st_d.burst = BURST_V1;
			end
			BURST_V1: begin
				st_d.rdata = st_q.v1;
				st_d.rvalid = 1'b1;
				st_d.burst = BURST_V2;
			end
			BURST_V2: begin
				st_d.rdata = st_q.v2;
				st_d.rvalid = 1'b1;
				st_d.burst = BURST_CRC;
			end
			BURST_CRC: begin
				st_d.rdata = {8'h00, st_q.smp_crc};
				st_d.rvalid = 1'b1;
				st_d.burst = BURST_FLAG;
			end
			BURST_FLAG: begin
				st_d.rdata = {16'h0000, flag_zero(st_q.prot, st_q.crc_chg)};
				st_d.rvalid = 1'b1;
				st_d.burst = BURST_IDLE;
				flag_read = 1'b1;
			end
			default: begin
				st_d.burst = BURST_IDLE;
			end
		endcase

		// clears first, so that any set below in the same cycle wins
		if (flag_read) begin
			st_d.crc_chg = 1'b0;
			st_d.prot = 1'b0;
		end
		if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_DISABLE) begin
			st_d.prot = 1'b0;
		end
		if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_ENABLE) begin
			st_d.prot = 1'b1;
		end

		// output cycle: capture samples and start both crc runs
		// a strobe inside a running crc restarts it and that result is lost
		if (cycle_strobe) begin
			st_d.cur = current_result;
			st_d.v1 = first_voltage_result;
			st_d.v2 = third_conv_result;
			st_d.smp_go = 1'b1;
			st_d.set_go = 1'b1;
			if (!rate_full) begin
				st_d.smp_crc = st_q.pend_crc;
			end
			if (st_q.locked) begin
				st_d.prot = 1'b1;
			end
		end

		// every result is parked for the next strobe, so a switch to a slow
		// rate publishes the crc of the previous cycle, not a stale one
		if (smp_if.done) begin
			st_d.pend_crc = smp_if.crc;
			if (rate_full) begin
				st_d.smp_crc = smp_if.crc;
			end
		end

		// setup crc result and its change flag
		if (set_if.done) begin
			st_d.set_crc = set_if.crc;
			if (set_if.crc != st_q.set_crc) begin
				st_d.crc_chg = 1'b1;
			end
		end

		// third converter input and settling of the temperature reading
		// the select is registered, so it trails the setup bit by one cycle and the variant pin by two
		st_d.sel_temp = st_q.setup[CFG_TEMP_SEL_BIT] | st_q.variant;
		if (!st_d.sel_temp) begin
			st_d.settle = '0;
			st_d.settled = 1'b0;
		end else if (!st_q.sel_temp) begin
			st_d.settle = SETTLE_LOAD;
			st_d.settled = 1'b0;
		end else if (st_q.settle > 1) begin
			st_d.settle = st_q.settle - 1'b1;
		end else begin
			st_d.settle = '0;
			st_d.settled = 1'b1;
		end
	end

	// single state register; protection off and setup at defaults after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.setup <= SETUP_RESET;
			st_q.ifc <= IFC_RESET;
			st_q.locked <= 1'b0;
			st_q.smp_crc <= CRC_REG_RESET;
			st_q.set_crc <= CRC_REG_RESET;
			st_q.boot <= 1'b1;
			st_q.burst <= BURST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// every output straight from the state register
	// read data holds its last word between answers
	assign reg_rdata = st_q.rdata;
	assign reg_rvalid = st_q.rvalid;
	assign output_rate_field = st_q.setup[CFG_RATE_HI:CFG_RATE_LO];
	assign narrow_band_bit = st_q.setup[CFG_NARROW_BIT];
	assign third_input_temp = st_q.sel_temp;
	assign interference_control = st_q.ifc;
	assign write_protect = st_q.locked;
	assign temp_settled = st_q.settled;

endmodule : sasi_integrity

`default_nettype wire

// ===== hw/sasi_pkg.sv
// Purpose: shared constants and types of the sample and setup integrity block
// Assumes: one 200 MHz clock, register accesses already decoded from the serial port
// Notes: all offsets, field positions, reset values and timing counts live here
`default_nettype none

package sasi_pkg;

	// register index map of the register access port
	localparam logic [3:0] ADDR_CURRENT = 4'h0;
	localparam logic [3:0] ADDR_FIRST_V = 4'h1;
	localparam logic [3:0] ADDR_SECOND_V = 4'h2;
	localparam logic [3:0] ADDR_SAMPLE_CRC = 4'h3;
	localparam logic [3:0] ADDR_SETUP = 4'h8;
	localparam logic [3:0] ADDR_FLAG_ZERO = 4'h9;
	localparam logic [3:0] ADDR_LOCK = 4'hA;
	localparam logic [3:0] ADDR_SETUP_CRC = 4'hB;
	localparam logic [3:0] ADDR_IFC = 4'hC;
	localparam logic [3:0] ADDR_TRIM = 4'hD;
	localparam logic [3:0] ADDR_FLAG_ONE = 4'hE;

	// lock register codes
	localparam logic [7:0] LOCK_ENABLE = 8'hCA;
	localparam logic [7:0] LOCK_DISABLE = 8'h9C;

	// setup register field positions
	localparam int CFG_TEMP_SEL_BIT = 3;
	localparam int CFG_RATE_LO = 4;
	localparam int CFG_RATE_HI = 5;
	localparam int CFG_NARROW_BIT = 7;
	localparam logic [1:0] RATE_FULL = 2'h0;

	// flag word field positions
	localparam int FLAG0_CRC_CHG_BIT = 1;
	localparam int FLAG0_PROT_BIT = 2;
	localparam int FLAG1_ARRAY_BIT = 7;

	// reset values
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] IFC_RESET = 8'h00;
	localparam logic [15:0] CRC_REG_RESET = 16'h0000;

	// crc generator
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam int SAMPLE_CRC_BITS = 72;
	localparam int SETUP_CRC_BITS = 64;

	// temperature settling time, in ms, and the clock rate in kHz
	localparam int TEMP_SETTLE_MS = 5;
	localparam int CLK_KHZ = 200000;
	localparam int TEMP_SETTLE_CYC = TEMP_SETTLE_MS * CLK_KHZ;
	localparam int SETTLE_W = 20;

	// burst read sequencer
	typedef enum logic [2:0] {
		BURST_IDLE = 3'b000,
		BURST_CUR = 3'b001,
		BURST_V1 = 3'b010,
		BURST_V2 = 3'b011,
		BURST_CRC = 3'b100,
		BURST_FLAG = 3'b101
	} sasi_burst_e;

endpackage : sasi_pkg

`default_nettype wire

// ===== hw/sasi_crc_if.sv
// Purpose: start/result handshake between the integrity top and a crc engine
// Assumes: start is a one-cycle pulse, data stable only in that cycle
// Notes: done pulses one cycle with crc valid from then on
`timescale 1ns/1ps
`default_nettype none

interface sasi_crc_if;
	logic start;
	logic [71:0] data;
	logic done;
	logic [15:0] crc;

	modport ctl(output start, output data, input done, input crc);
	modport eng(input start, input data, output done, output crc);
endinterface : sasi_crc_if

`default_nettype wire

// ===== hw/sasi_crc_engine.sv
// Purpose: serial ccitt crc over a byte-ordered bit array, one bit per clock
// Assumes: LEN is a multiple of eight and at most 72
// Notes: result appears LEN+1 cycles after start; a new start restarts the run
`timescale 1ns/1ps
`default_nettype none

module sasi_crc_engine #(
	parameter int LEN = 72
) (
	input wire logic clk,
	input wire logic rst,
	sasi_crc_if.eng bus
);
	import sasi_pkg::*;

	localparam logic [6:0] LAST_STEP = 7'(LEN - 1);

	typedef struct packed {
		logic busy;
		logic [6:0] cnt;
		logic [71:0] data;
		logic [15:0] lfsr;
		logic done;
		logic [15:0] crc;
	} sasi_eng_s;

	sasi_eng_s st_q;
	sasi_eng_s st_d;

	// one lfsr step per clock while busy
	always_comb begin
		logic in_bit;
		logic fb;
		in_bit = 1'b0;
		fb = 1'b0;
		st_d = st_q;
		st_d.done = 1'b0;
		if (bus.start) begin
			st_d.busy = 1'b1;
			st_d.cnt = 7'h00;
			st_d.data = bus.data;
			st_d.lfsr = CRC_PRESET;
		end else if (st_q.busy) begin
			// low byte first, each byte from its top bit down
			in_bit = st_q.data[{st_q.cnt[6:3], ~st_q.cnt[2:0]}];
			fb = in_bit ^ st_q.lfsr[15];
			st_d.lfsr = {st_q.lfsr[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
			st_d.cnt = st_q.cnt + 7'h01;
			if (st_q.cnt == LAST_STEP) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
				st_d.crc = st_d.lfsr;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.done = st_q.done;
	assign bus.crc = st_q.crc;

endmodule : sasi_crc_engine

`default_nettype wire

// ===== dv/sasi_integrity_assertions.sv
// Purpose: port-level checker for the integrity block
// Assumes: register strobes are one-cycle pulses, writes spaced by a cycle
// Notes: bound below to every instance of the block
`timescale 1ns/1ps
`default_nettype none

module sasi_integrity_assertions import sasi_pkg::*; #(
	parameter int unsigned TEMP_SETTLE_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic two_channel_variant,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic burst_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic [1:0] output_rate_field,
	input wire logic narrow_band_bit,
	input wire logic third_input_temp,
	input wire logic [7:0] interference_control,
	input wire logic write_protect,
	input wire logic temp_settled
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// decoded write kinds
	wire logic lock_wr = reg_wr && reg_addr == ADDR_LOCK;
	wire logic key_wr = lock_wr && (reg_wdata == LOCK_ENABLE || reg_wdata == LOCK_DISABLE);
	wire logic cfg_wr = reg_wr && reg_addr == ADDR_SETUP;
	int unsigned settle_q;
	int unsigned settle_d;

	// cycles with temperature selected, saturating so it never wraps
	always_comb begin
		settle_d = 0;
		if (third_input_temp) begin
			settle_d = settle_q < TEMP_SETTLE_CYCLES ? settle_q + 1 : settle_q;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_q <= 0;
		end else begin
			settle_q <= settle_d;
		end
	end

	read_answer_a: assert property (reg_rd && !burst_rd |=> reg_rvalid)
		else $error("single read gave no word");
	burst_words_a: assert property (burst_rd && !reg_rvalid |=> !reg_rvalid ##1 reg_rvalid [*5] ##1 !reg_rvalid)
		else $error("burst did not return five words");
	lock_on_a: assert property (lock_wr && reg_wdata == LOCK_ENABLE |=> write_protect)
		else $error("enable code did not lock");
	lock_off_a: assert property (lock_wr && reg_wdata == LOCK_DISABLE |=> !write_protect)
		else $error("disable code did not unlock");
	lock_hold_a: assert property (!key_wr |=> $stable(write_protect))
		else $error("lock state moved without a key");
	setup_write_a: assert property (cfg_wr && !write_protect |-> ##2 output_rate_field == $past(reg_wdata[5:4], 2) && narrow_band_bit == $past(reg_wdata[7], 2))
		else $error("setup write not applied");
	setup_locked_a: assert property (cfg_wr && write_protect |=> $stable(output_rate_field) && $stable(narrow_band_bit))
		else $error("setup changed while locked");
	ifc_locked_a: assert property (reg_wr && reg_addr == ADDR_IFC && write_protect |=> $stable(interference_control))
		else $error("interference control changed while locked");
	variant_temp_a: assert property (two_channel_variant |-> ##2 third_input_temp)
		else $error("two-channel part not on temperature");
	temp_settle_a: assert property (temp_settled == (third_input_temp && settle_q >= TEMP_SETTLE_CYCLES))
		else $error("settled flag off its count");

	// main scenarios reached
	cover property (burst_rd);
	cover property (lock_wr && reg_wdata == LOCK_ENABLE);
	cover property (cfg_wr && write_protect);
	cover property ($rose(temp_settled));
endmodule : sasi_integrity_assertions

bind sasi_integrity sasi_integrity_assertions #(.TEMP_SETTLE_CYCLES(TEMP_SETTLE_CYCLES)) chk (
	.clk(clk), .rst(rst), .two_channel_variant(two_channel_variant), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .burst_rd(burst_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rvalid(reg_rvalid), .output_rate_field(output_rate_field),
	.narrow_band_bit(narrow_band_bit), .third_input_temp(third_input_temp),
	.interference_control(interference_control), .write_protect(write_protect),
	.temp_settled(temp_settled));

`default_nettype wire

// ===== dv/sasi_host_model.sv
// Purpose: host model driving the decoded register port
// Assumes: requests change at the falling edge, one per request cycle
// Notes: the write task takes any index, the lock register included
`timescale 1ns/1ps
`default_nettype none

module sasi_host_model (
	input wire logic clk,
	input wire logic [23:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic reg_wr,
	output logic reg_rd,
	output logic burst_rd,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata
);
	logic [23:0] bw [5];
	logic bv [5];

	// idle port at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		burst_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end

	// one write, taken at the next rising edge; any index, the setup register included
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	// one read, word returned in the cycle after the taking edge
	task automatic rd(input logic [3:0] a, output logic [23:0] q, output logic v);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		q = reg_rdata;
		v = reg_rvalid;
	endtask : rd

	// burst start, then five words two to six cycles later
	task automatic burst();
		@(negedge clk);
		burst_rd = 1'b1;
		@(negedge clk);
		burst_rd = 1'b0;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			bw[i] = reg_rdata;
			bv[i] = reg_rvalid;
		end
	endtask : burst
endmodule : sasi_host_model

`default_nettype wire

// ===== dv/sasi_integrity_test.sv
// Purpose: self-checking bench for the integrity block
// Assumes: settle count shortened to 20 cycles
// Notes: expected crcs come from a bit-serial model of the generator
`timescale 1ns/1ps
`default_nettype none

module sasi_integrity_test;
	import sasi_pkg::*;
	logic clk, rst, cycle_strobe, variant;
	logic [23:0] cur, v1, third, rdata, q;
	logic [7:0] fuse, f1, cfg, ifc;
	logic rvalid, wr, rd, brd, v, prot, tmp, settled, nb;
	logic [3:0] addr;
	logic [7:0] wdata, ifc_out;
	logic [1:0] rate;
	logic [71:0] s, prev;
	logic [23:0] exp [5];
	int seed, num_errors, num_checks;

	sasi_integrity #(.TEMP_SETTLE_CYCLES(20)) DUT (.clk(clk), .rst(rst),
		.cycle_strobe(cycle_strobe), .current_result(cur), .first_voltage_result(v1),
		.third_conv_result(third), .two_channel_variant(variant), .thermal_offset_fuse(fuse),
		.flag_word_one(f1), .reg_wr(wr), .reg_rd(rd), .burst_rd(brd), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .output_rate_field(rate),
		.narrow_band_bit(nb), .third_input_temp(tmp), .interference_control(ifc_out),
		.write_protect(prot), .temp_settled(settled));
	sasi_host_model host (.clk(clk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_wr(wr),
		.reg_rd(rd), .burst_rd(brd), .reg_addr(addr), .reg_wdata(wdata));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// bit-serial crc: bytes low first, each from its top bit
	function automatic logic [15:0] crc16(input logic [71:0] d, input int nb);
		logic [15:0] c;
		logic fb;
		c = 16'hFFFF;
		for (int i = 0; i < nb * 8; i++) begin
			fb = d[(i / 8) * 8 + 7 - i % 8] ^ c[15];
			c = {c[14:0], 1'b0} ^ ({16{fb}} & 16'h1021);
		end
		return c;
	endfunction : crc16

	task automatic check(input string n, input logic [23:0] seen, input logic [23:0] e);
		num_checks++;
		if (seen !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, seen);
		end
	endtask : check

	task automatic rdchk(input string n, input logic [3:0] a, input logic [23:0] e);
		host.rd(a, q, v);
		check({n, " valid"}, 24'(v), 24'h00_0001);
		check(n, q, e);
	endtask : rdchk

	// new samples, one strobe, then room for both crc runs
	task automatic strobe();
		@(negedge clk);
		{third, v1, cur} = s;
		cycle_strobe = 1'b1;
		@(negedge clk);
		cycle_strobe = 1'b0;
		repeat (80) @(negedge clk);
	endtask : strobe

	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	// hang guard, well beyond the run's length
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		seed = 44957;
		{cycle_strobe, variant, cur, v1, third, s, prev} = '0;
		fuse = 8'($random(seed));
		f1 = 8'($random(seed));
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (80) @(negedge clk);
		check("unlocked at reset", 24'(prot), 24'h00_0000);
		rdchk("setup reset", ADDR_SETUP, 24'h00_0000);
		rdchk("lock reads zero", ADDR_LOCK, 24'h00_0000);
		rdchk("boot crc flag", ADDR_FLAG_ZERO, 24'h00_0002);
		rdchk("flag cleared", ADDR_FLAG_ZERO, 24'h00_0000);
		rdchk("trim", ADDR_TRIM, {16'h0000, fuse});
		rdchk("flag one", ADDR_FLAG_ONE, {16'h0000, f1});
		ifc = 8'($random(seed));
		host.wr(ADDR_IFC, ifc);
		rdchk("ifc", ADDR_IFC, {16'h0000, ifc});
		// every rate code, with all-ones and all-zero corner samples
		for (int r = 0; r < 4; r++) begin
			cfg = 8'($random(seed));
			cfg[5:4] = 2'(r);
			host.wr(ADDR_SETUP, cfg);
			repeat (2) @(negedge clk);
			check("rate", 24'(rate), 24'(r));
			check("temp select", 24'(tmp), 24'(cfg[3]));
			check("narrow band", 24'(nb), 24'(cfg[7]));
			prev = s;
			s = {24'($random(seed)), 24'($random(seed)), 24'($random(seed))};
			if (r == 0) s = '1;
			if (r == 3) s = '0;
			strobe();
			rdchk("current", ADDR_CURRENT, s[23:0]);
			rdchk("first v", ADDR_FIRST_V, s[47:24]);
			rdchk("second v", ADDR_SECOND_V, s[71:48]);
			rdchk("sample crc", ADDR_SAMPLE_CRC, {8'h00, crc16(r == 0 ? s : prev, 9)});
			rdchk("setup crc", ADDR_SETUP_CRC, {8'h00, crc16({24'h00_0000, f1 & 8'h80, 8'h00, fuse, ifc, cfg}, 8)});
		end
		// burst after clearing flags
		host.rd(ADDR_FLAG_ZERO, q, v);
		exp = '{s[23:0], s[47:24], s[71:48], {8'h00, crc16(prev, 9)}, 24'h00_0000};
		host.burst();
		for (int i = 0; i < 5; i++) begin
			check("burst valid", 24'(host.bv[i]), 24'h00_0001);
			check("burst word", host.bw[i], exp[i]);
		end
		// lock, try blocked writes and a stray key, then unlock and change
		host.wr(ADDR_LOCK, LOCK_ENABLE);
		check("locked", 24'(prot), 24'h00_0001);
		host.wr(ADDR_SETUP, ~cfg);
		host.wr(ADDR_IFC, ~ifc);
		host.wr(ADDR_LOCK, 8'h55);
		check("stray key", 24'(prot), 24'h00_0001);
		rdchk("setup kept", ADDR_SETUP, {16'h0000, cfg});
		check("ifc kept", 24'(ifc_out), 24'(ifc));
		rdchk("prot flag", ADDR_FLAG_ZERO, 24'h00_0004);
		rdchk("prot cleared", ADDR_FLAG_ZERO, 24'h00_0000);
		strobe();
		host.rd(ADDR_FLAG_ZERO, q, v);
		check("prot flag again", 24'(q[2]), 24'h00_0001);
		host.wr(ADDR_LOCK, LOCK_DISABLE);
		check("unlocked", 24'(prot), 24'h00_0000);
		host.wr(ADDR_SETUP, 8'h00);
		rdchk("setup changed", ADDR_SETUP, 24'h00_0000);
		// two-channel part forces temperature, select bit clear
		@(negedge clk);
		variant = 1'b1;
		repeat (2) @(negedge clk);
		check("forced temp", 24'(tmp), 24'h00_0001);
		check("not settled", 24'(settled), 24'h00_0000);
		repeat (21) @(negedge clk);
		check("settled", 24'(settled), 24'h00_0001);
		tally_and_finish();
	end
endmodule : sasi_integrity_test

`default_nettype wire
